/* include/aliu_defines.vh */
// Constants of the arithmetic and logic execution unit.
// Included by the design files; holds definitions only.
`ifndef ALIU_DEFINES_VH
`define ALIU_DEFINES_VH

// Operation codes presented by the instruction decoder
`define ALIU_OP_ADD       4'h0
`define ALIU_OP_ADC       4'h1
`define ALIU_OP_SUB       4'h2
`define ALIU_OP_MINUS_REG_REG_BORROW 4'h3
`define ALIU_OP_SUB_IMM   4'h4
`define ALIU_OP_MINUS_REG_IMM_BORROW 4'h5
`define ALIU_OP_AND       4'h6
`define ALIU_OP_AND_IMM   4'h7
`define ALIU_OP_OR        4'h8
`define ALIU_OP_OR_IMM    4'h9
`define ALIU_OP_WADD_IMM  4'ha
`define ALIU_OP_WSUB_IMM  4'hb
`define ALIU_OP_IO_CLR    4'hc
`define ALIU_OP_IO_SET    4'hd

// Status flag bit positions
`define ALIU_FLG_C        0
`define ALIU_FLG_Z        1
`define ALIU_FLG_N        2
`define ALIU_FLG_V        3
`define ALIU_FLG_S        4
`define ALIU_FLG_H        5
`define ALIU_FLG_RST      8'h00

// Highest I/O address the bit instructions may touch
`define ALIU_IO_BIT_MAX   6'h1f
// Address of the local status register with write-one-to-clear flags
`define ALIU_STAT_ADDR    6'h1e
`define ALIU_STAT_RST     8'h00

// Cycle counts per operation class
`define ALIU_CYC_BYTE     1
`define ALIU_CYC_WORD     2

`endif

/* hdl/aliu_w1c_flags.v */
// Local peripheral status register whose flags clear on a written one.
// Events come from logic on mclk; writes come from the I/O bit path.
`timescale 1ns/1ns
`default_nettype none
`include "aliu_defines.vh"

module aliu_w1c_flags
(
	// Clock and reset
	input  wire       mclk,
	input  wire       rst_n,
	// Hardware events, one bit per flag
	input  wire [7:0] evt,
	// Write port
	input  wire       wr_en,
	input  wire [7:0] wr_data,
	// Flag state
	output reg  [7:0] stat_q
);

	reg [7:0] stat_d;

	// A one clears, a zero keeps; an event in the clearing cycle still sets
	always @*
	begin
		stat_d = stat_q;
		if (wr_en)
			stat_d = stat_d & ~wr_data;
		stat_d = stat_d | evt;
	end

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			stat_q <= `ALIU_STAT_RST;
		else
			stat_q <= stat_d;
	end

endmodule // aliu_w1c_flags

`default_nettype wire

/* hdl/aliu_core.v */
// Arithmetic and logic execution unit of a small 8-bit core.
// Operands come from a decoder and register file on mclk; results and
// flags return as registered outputs, I/O bit accesses drive an I/O bus.
`timescale 1ns/1ns
`default_nettype none
`include "aliu_defines.vh"

module aliu_core
(
	// Clock and reset
	input  wire        mclk,
	input  wire        rst_n,
	// Request from the decoder
	input  wire        op_valid,
	input  wire [3:0]  op_code,
	input  wire [7:0]  dst_lo,
	input  wire [7:0]  dst_hi,
	input  wire [7:0]  src_operand,
	input  wire [7:0]  imm,
	input  wire [5:0]  io_sel,
	input  wire [2:0]  io_bit,
	output reg         op_ready_q,
	output reg         op_error_q,
	// Result toward the register file
	output reg         res_valid_q,
	output reg         res_wide_q,
	output reg  [7:0]  res_lo_q,
	output reg  [7:0]  res_hi_q,
	output reg  [7:0]  flags_q,
	// I/O bus for the bit instructions
	output reg         io_re_q,
	output reg         io_we_q,
	output reg  [5:0]  io_addr_q,
	output reg  [7:0]  io_wdata_q,
	input  wire [7:0]  io_rdata,
	// Local status register
	input  wire [7:0]  stat_evt,
	output wire [7:0]  stat_q
);

	localparam [2:0] ST_IDLE  = 3'b001;
	localparam [2:0] ST_WORD  = 3'b010;
	localparam [2:0] ST_IO_WR = 3'b100;

	// Carry or borrow out of a bit position, from operands and result
	function carry_fn;
		input a;
		input b;
		input r;
		input sub;
		begin
			if (sub)
				carry_fn = (~a & b) | (b & r) | (r & ~a);
			else
				carry_fn = (a & b) | (b & ~r) | (~r & a);
		end
	endfunction

	// Two's complement overflow at the top bit
	function ovf_fn;
		input a;
		input b;
		input r;
		input sub;
		begin
			if (sub)
				ovf_fn = (a & ~b & ~r) | (~a & b & r);
			else
				ovf_fn = (a & b & ~r) | (~a & ~b & r);
		end
	endfunction

	reg [2:0]  state_q;
	reg [2:0]  state_d;
	reg [2:0]  bit_q;
	reg        set_q;
	reg [7:0]  wlo_q;
	reg [7:0]  whi_q;
	reg [7:0]  wflags_q;

	reg        is_byte;
	reg        is_sub;
	reg        is_logic;
	reg        use_imm;
	reg        use_cin;
	reg        is_word;
	reg        is_io;
	reg [7:0]  opb;
	reg        cin;
	reg [7:0]  byte_r;
	reg [15:0] word_in;
	reg [15:0] word_r;
	reg [7:0]  fl_byte;
	reg [7:0]  fl_word;
	reg [7:0]  io_cur;
	reg [7:0]  io_mask;
	wire       take;
	wire       stat_we;

	assign take = op_valid && op_ready_q;

	// Operation decode
	always @*
	begin
		is_byte  = 1'b0;
		is_sub   = 1'b0;
		is_logic = 1'b0;
		use_imm  = 1'b0;
		use_cin  = 1'b0;
		is_word  = 1'b0;
		is_io    = 1'b0;
		case (op_code)
			`ALIU_OP_ADD:      is_byte = 1'b1;
			`ALIU_OP_ADC:
			begin
				is_byte = 1'b1;
				use_cin = 1'b1;
			end
			`ALIU_OP_SUB:
			begin
				is_byte = 1'b1;
				is_sub  = 1'b1;
			end
			`ALIU_OP_MINUS_REG_REG_BORROW:
			begin
				is_byte = 1'b1;
				is_sub  = 1'b1;
				use_cin = 1'b1;
			end
			`ALIU_OP_SUB_IMM:
			begin
				is_byte = 1'b1;
				is_sub  = 1'b1;
				use_imm = 1'b1;
			end
			`ALIU_OP_MINUS_REG_IMM_BORROW:
			begin
				is_byte = 1'b1;
				is_sub  = 1'b1;
				use_imm = 1'b1;
				use_cin = 1'b1;
			end
			`ALIU_OP_AND, `ALIU_OP_OR:
			begin
				is_byte  = 1'b1;
				is_logic = 1'b1;
			end
			`ALIU_OP_AND_IMM, `ALIU_OP_OR_IMM:
			begin
				is_byte  = 1'b1;
				is_logic = 1'b1;
				use_imm  = 1'b1;
			end
			`ALIU_OP_WADD_IMM: is_word = 1'b1;
			`ALIU_OP_WSUB_IMM:
			begin
				is_word = 1'b1;
				is_sub  = 1'b1;
			end
			`ALIU_OP_IO_CLR, `ALIU_OP_IO_SET: is_io = 1'b1;
			default:           is_byte = 1'b0;
		endcase
	end

	// Byte datapath and its flags
	always @*
	begin
		opb = use_imm ? imm : src_operand;
		cin = use_cin & flags_q[`ALIU_FLG_C];
		if (op_code == `ALIU_OP_AND || op_code == `ALIU_OP_AND_IMM)
			byte_r = dst_lo & opb;
		else if (op_code == `ALIU_OP_OR || op_code == `ALIU_OP_OR_IMM)
			byte_r = dst_lo | opb;
		else if (is_sub)
			byte_r = dst_lo - opb - {7'h00, cin};
		else
			byte_r = dst_lo + opb + {7'h00, cin};
		fl_byte = flags_q;
		fl_byte[`ALIU_FLG_Z] = (byte_r == 8'h00);
		fl_byte[`ALIU_FLG_N] = byte_r[7];
		if (is_logic)
		begin
			// Logic ops leave C, S and H as they were
			fl_byte[`ALIU_FLG_V] = 1'b0;
		end
		else
		begin
			fl_byte[`ALIU_FLG_C] = carry_fn(dst_lo[7], opb[7], byte_r[7], is_sub);
			fl_byte[`ALIU_FLG_H] = carry_fn(dst_lo[3], opb[3], byte_r[3], is_sub);
			fl_byte[`ALIU_FLG_V] = ovf_fn(dst_lo[7], opb[7], byte_r[7], is_sub);
		end
	end

	// Word datapath over the register pair; immediate is zero-extended
	always @*
	begin
		word_in = {dst_hi, dst_lo};
		if (is_sub)
			word_r = word_in - {8'h00, imm};
		else
			word_r = word_in + {8'h00, imm};
		fl_word = flags_q;
		fl_word[`ALIU_FLG_Z] = (word_r == 16'h0000);
		fl_word[`ALIU_FLG_N] = word_r[15];
		fl_word[`ALIU_FLG_C] = carry_fn(dst_hi[7], 1'b0, word_r[15], is_sub);
		fl_word[`ALIU_FLG_V] = ovf_fn(dst_hi[7], 1'b0, word_r[15], is_sub);
		fl_word[`ALIU_FLG_S] = fl_word[`ALIU_FLG_N] ^ fl_word[`ALIU_FLG_V];
	end

	// Read data of the current I/O access and the modified value
	always @*
	begin
		if (io_addr_q == `ALIU_STAT_ADDR)
			io_cur = stat_q;
		else
			io_cur = io_rdata;
		io_mask = 8'h01 << bit_q;
		// Whole register goes back, so set flags other than a cleared bit return as ones
		if (set_q)
			io_mask = io_cur | io_mask;
		else
			io_mask = io_cur & ~io_mask;
	end

	// Sequencer
	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
			begin
				if (take && is_word)
					state_d = ST_WORD;
				else if (take && is_io && io_sel <= `ALIU_IO_BIT_MAX)
					state_d = ST_IO_WR;
			end
			ST_WORD:  state_d = ST_IDLE;
			ST_IO_WR: state_d = ST_IDLE;
			default:  state_d = ST_IDLE;
		endcase
	end

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q     <= ST_IDLE;
			op_ready_q  <= 1'b1;
			op_error_q  <= 1'b0;
			res_valid_q <= 1'b0;
			res_wide_q  <= 1'b0;
			res_lo_q    <= 8'h00;
			res_hi_q    <= 8'h00;
			flags_q     <= `ALIU_FLG_RST;
			io_re_q     <= 1'b0;
			io_we_q     <= 1'b0;
			io_addr_q   <= 6'h00;
			io_wdata_q  <= 8'h00;
			bit_q       <= 3'h0;
			set_q       <= 1'b0;
			wlo_q       <= 8'h00;
			whi_q       <= 8'h00;
			wflags_q    <= 8'h00;
		end
		else
		begin
			state_q     <= state_d;
			op_ready_q  <= (state_d == ST_IDLE);
			op_error_q  <= 1'b0;
			res_valid_q <= 1'b0;
			res_wide_q  <= 1'b0;
			io_re_q     <= 1'b0;
			io_we_q     <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					if (take && is_byte)
					begin
						res_valid_q <= 1'b1;
						res_lo_q    <= byte_r;
						res_hi_q    <= dst_hi;
						flags_q     <= fl_byte;
					end
					else if (take && is_word)
					begin
						wlo_q    <= word_r[7:0];
						whi_q    <= word_r[15:8];
						wflags_q <= fl_word;
					end
					else if (take && is_io)
					begin
						if (io_sel <= `ALIU_IO_BIT_MAX)
						begin
							io_re_q   <= 1'b1;
							io_addr_q <= io_sel;
							bit_q     <= io_bit;
							set_q     <= (op_code == `ALIU_OP_IO_SET);
						end
						else
							op_error_q <= 1'b1;
					end
					else if (take)
						op_error_q <= 1'b1;
				end
				ST_WORD:
				begin
					// Second clock of a word op hands over both halves
					res_valid_q <= 1'b1;
					res_wide_q  <= 1'b1;
					res_lo_q    <= wlo_q;
					res_hi_q    <= whi_q;
					flags_q     <= wflags_q;
				end
				ST_IO_WR:
				begin
					io_we_q    <= 1'b1;
					io_wdata_q <= io_mask;
				end
				default:
				begin
					op_error_q <= 1'b0;
				end
			endcase
		end
	end

	assign stat_we = io_we_q && (io_addr_q == `ALIU_STAT_ADDR);

	aliu_w1c_flags u_stat
	(
		.mclk    (mclk),
		.rst_n   (rst_n),
		.evt     (stat_evt),
		.wr_en   (stat_we),
		.wr_data (io_wdata_q),
		.stat_q  (stat_q)
	);

endmodule // aliu_core

`default_nettype wire

/* test/aliu_core_assertions.sv */
// Port checker of the execution unit: timing and flag relations.
// Bound to aliu_core below; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
`include "aliu_defines.vh"

module aliu_core_chk
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// Request
	input  wire logic       op_valid,
	input  wire logic [3:0] op_code,
	input  wire logic [5:0] io_sel,
	input  wire logic [2:0] io_bit,
	input  wire logic       op_ready_q,
	input  wire logic       op_error_q,
	// Result
	input  wire logic       res_valid_q,
	input  wire logic       res_wide_q,
	input  wire logic [7:0] res_lo_q,
	input  wire logic [7:0] flags_q,
	// I/O bus and status
	input  wire logic       io_re_q,
	input  wire logic       io_we_q,
	input  wire logic [5:0] io_addr_q,
	input  wire logic [7:0] io_wdata_q,
	input  wire logic [7:0] io_rdata,
	input  wire logic [7:0] stat_evt,
	input  wire logic [7:0] stat_q
);
	wire tk;

	assign tk = op_valid && op_ready_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_byte_one: assert property (
		tk && op_code <= `ALIU_OP_OR_IMM |=> res_valid_q && !res_wide_q && op_ready_q)
		else $error("byte op result late");
	a_arith_zn: assert property (
		tk && op_code <= `ALIU_OP_MINUS_REG_IMM_BORROW |=> flags_q[1] == (res_lo_q == 8'h00)
		&& flags_q[2] == res_lo_q[7])
		else $error("arith zero or negative flag wrong");
	a_logic_flags: assert property (
		tk && op_code >= `ALIU_OP_AND && op_code <= `ALIU_OP_OR_IMM
		|=> !flags_q[3] && flags_q[0] == $past(flags_q[0]))
		else $error("logic op flags wrong");
	a_word_two: assert property (
		tk && (op_code == `ALIU_OP_WADD_IMM || op_code == `ALIU_OP_WSUB_IMM)
		|=> !op_ready_q && !res_valid_q ##1 res_valid_q && res_wide_q)
		else $error("word op timing wrong");
	a_sign_flag: assert property (
		res_valid_q && res_wide_q |-> flags_q[4] == (flags_q[2] ^ flags_q[3]))
		else $error("sign flag not n xor v");
	a_io_range: assert property (
		tk && op_code >= `ALIU_OP_IO_CLR && op_code <= `ALIU_OP_IO_SET
		&& io_sel > `ALIU_IO_BIT_MAX |=> op_error_q && !io_re_q)
		else $error("out of range io access taken");
	a_io_rmw: assert property (
		io_re_q |=> io_we_q && $stable(io_addr_q))
		else $error("io write does not follow read");
	a_io_set_data: assert property (
		tk && op_code == `ALIU_OP_IO_SET && io_sel <= `ALIU_IO_BIT_MAX
		|=> ##1 io_wdata_q == (($past(io_addr_q) == `ALIU_STAT_ADDR ? $past(stat_q)
		: $past(io_rdata)) | (8'h01 << $past(io_bit, 2))))
		else $error("io set write data wrong");
	a_stat_w1c: assert property (
		io_we_q && io_addr_q == `ALIU_STAT_ADDR && stat_evt == 8'h00
		|=> stat_q == ($past(stat_q) & ~$past(io_wdata_q)))
		else $error("status flags not cleared by ones");
endmodule // aliu_core_chk

bind aliu_core aliu_core_chk aliu_core_chk_i (.mclk, .rst_n, .op_valid, .op_code, .io_sel,
	.io_bit, .op_ready_q, .op_error_q, .res_valid_q, .res_wide_q, .res_lo_q, .flags_q,
	.io_re_q, .io_we_q, .io_addr_q, .io_wdata_q, .io_rdata, .stat_evt, .stat_q);

`default_nettype wire

/* test/aliu_io_model.sv */
// I/O register space seen by the bit instructions.
// Replies in the read cycle; local status comes from the unit itself.
`timescale 1ns/1ns
`default_nettype none

module aliu_io_model
(
	// I/O bus from the unit
	input  wire logic       mclk,
	input  wire logic       io_re_q,
	input  wire logic       io_we_q,
	input  wire logic [5:0] io_addr_q,
	input  wire logic [7:0] io_wdata_q,
	input  wire logic [7:0] stat_q,
	// Read reply
	output var  logic [7:0] io_rdata
);
	logic [7:0] mem_q [32];
	logic [7:0] last_q = 8'h00;

	initial
		for (int i = 0; i < 32; i++)
			mem_q[i] = 8'h5a;

	// Off-read the bus shows no stale value, so a late sample is caught
	always @*
		io_rdata = !io_re_q ? ~last_q : io_addr_q == 6'h1e ? stat_q : mem_q[io_addr_q[4:0]];

	always @(posedge mclk)
	begin
		if (io_re_q)
			last_q <= io_rdata;
		if (io_we_q)
			mem_q[io_addr_q[4:0]] <= io_wdata_q;
	end
endmodule // aliu_io_model

`default_nettype wire

/* test/aliu_core_test.sv */
// Self-checking bench of the execution unit.
// Assumes an I/O space model on the bit-instruction bus.
`timescale 1ns/1ns
`default_nettype none
`include "aliu_defines.vh"

module aliu_core_test;
	logic       mclk, rst_n, op_valid, op_ready_q, op_error_q, res_valid_q, res_wide_q;
	logic       io_re_q, io_we_q, cf;
	logic [2:0] io_bit;
	logic [3:0] op_code;
	logic [5:0] io_sel, io_addr_q;
	logic [7:0] dst_lo, dst_hi, src_operand, imm, res_lo_q, res_hi_q, flags_q;
	logic [7:0] io_wdata_q, io_rdata, stat_evt, stat_q;
	int         errors, tests_run;

	aliu_core aliu_core_i (.mclk, .rst_n, .op_valid, .op_code, .dst_lo, .dst_hi,
		.src_operand, .imm, .io_sel, .io_bit, .op_ready_q, .op_error_q, .res_valid_q,
		.res_wide_q, .res_lo_q, .res_hi_q, .flags_q, .io_re_q, .io_we_q, .io_addr_q,
		.io_wdata_q, .io_rdata, .stat_evt, .stat_q);
	aliu_io_model aliu_io_model_i (.mclk, .io_re_q, .io_we_q, .io_addr_q, .io_wdata_q,
		.stat_q, .io_rdata);

	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One request held to its take edge, outputs sampled mid-cycle after it
	task automatic issue(input logic [3:0] c, input logic [15:0] p, input logic [7:0] s,
		input logic [7:0] k, input logic [5:0] a, input logic [2:0] b);
		@(posedge mclk);
		op_valid <= 1'b1;
		op_code <= c;
		{dst_hi, dst_lo} <= p;
		src_operand <= s;
		imm <= k;
		io_sel <= a;
		io_bit <= b;
		@(posedge mclk);
		op_valid <= 1'b0;
		@(negedge mclk);
	endtask

	function automatic logic [15:0] ar(input logic sub, input logic [7:0] a, b,
		input logic ci);
		logic [8:0] r;
		logic [4:0] h;
		r = sub ? {1'b0, a} - b - ci : a + b + ci;
		h = sub ? {1'b0, a[3:0]} - b[3:0] - ci : a[3:0] + b[3:0] + ci;
		return {2'b00, h[4], 1'b0, (a[7] ^ r[7]) & (sub ^ ~(a[7] ^ b[7])), r[7],
			r[7:0] == 8'h00, r[8], r[7:0]};
	endfunction

	function automatic logic [23:0] wd(input logic sub, input logic [15:0] p,
		input logic [7:0] k);
		logic [16:0] r;
		logic        v;
		r = sub ? {1'b0, p} - k : p + k;
		v = sub ? p[15] & ~r[15] : ~p[15] & r[15];
		return {3'h0, r[15] ^ v, v, r[15], r[15:0] == 16'h0000, r[16], r[15:0]};
	endfunction

	task automatic t_byte;
		logic [3:0]  cd [8] = '{4'h0, 4'h1, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h5};
		logic [7:0]  av [8] = '{8'h7f, 8'hff, 8'h00, 8'h00, 8'h10, 8'h80, 8'h00, 8'h05};
		logic [7:0]  bv [8] = '{8'h01, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h01, 8'h04};
		logic [15:0] e;
		for (int i = 0; i < 8; i++)
		begin
			e = ar(cd[i] > 4'h1, av[i], bv[i], cd[i][0] & cf);
			// The unused operand differs, so a wrong operand select shows
			issue(cd[i], {8'h00, av[i]}, cd[i] > 4'h3 ? ~bv[i] : bv[i],
				cd[i] > 4'h3 ? bv[i] : ~bv[i], 6'h00, 3'h0);
			chk({res_valid_q, res_lo_q}, {1'b1, e[7:0]});
			chk(flags_q & 8'hef, e[15:8]);
			cf = e[8];
		end
		$display("byte arithmetic test done");
	endtask

	task automatic t_logic;
		logic [7:0] av [4] = '{8'ha5, 8'hf0, 8'h00, 8'h80};
		logic [7:0] bv [4] = '{8'h5a, 8'hc3, 8'h00, 8'h01};
		logic [7:0] r;
		logic [3:0] c;
		for (int i = 0; i < 4; i++)
		begin
			c = `ALIU_OP_AND + 4'(i);
			r = i < 2 ? av[i] & bv[i] : av[i] | bv[i];
			issue(c, {8'h00, av[i]}, c[0] ? ~bv[i] : bv[i], c[0] ? bv[i] : ~bv[i], 6'h00, 3'h0);
			chk({res_lo_q, flags_q & 8'h0f}, {r, 5'h00, r[7], r == 8'h00, cf});
		end
		$display("logic test done");
	endtask

	task automatic t_word;
		logic [15:0] pv [3] = '{16'hffff, 16'h0000, 16'h7fff};
		logic [7:0]  kv [3] = '{8'h01, 8'hff, 8'h01};
		logic [23:0] e;
		for (int i = 0; i < 3; i++)
		begin
			e = wd(i == 1, pv[i], kv[i]);
			issue(i == 1 ? `ALIU_OP_WSUB_IMM : `ALIU_OP_WADD_IMM, pv[i], 8'h00, kv[i], 6'h00, 3'h0);
			chk({op_ready_q, res_valid_q}, 2'b00);
			@(negedge mclk);
			chk({res_valid_q, res_wide_q, res_hi_q, res_lo_q}, {2'b11, e[15:0]});
			chk(flags_q & 8'h1f, e[23:16]);
		end
		$display("word test done");
	endtask

	task automatic io_op(input logic [3:0] c, input logic [5:0] a, input logic [2:0] b,
		input logic [7:0] w);
		issue(c, 16'h0000, 8'h00, 8'h00, a, b);
		chk({io_re_q, io_we_q, op_ready_q, io_addr_q}, {3'b100, a});
		@(negedge mclk);
		chk({io_we_q, io_addr_q, io_wdata_q}, {1'b1, a, w});
		@(negedge mclk);
	endtask

	task automatic t_io;
		io_op(`ALIU_OP_IO_SET, 6'h05, 3'h0, 8'h5b);
		io_op(`ALIU_OP_IO_CLR, 6'h05, 3'h1, 8'h59);
		io_op(`ALIU_OP_IO_SET, 6'h1f, 3'h7, 8'hda);
		@(posedge mclk);
		stat_evt <= 8'h05;
		@(posedge mclk);
		stat_evt <= 8'h00;
		@(negedge mclk);
		chk(stat_q, 8'h05);
		io_op(`ALIU_OP_IO_CLR, `ALIU_STAT_ADDR, 3'h0, 8'h04);
		chk(stat_q, 8'h01);
		io_op(`ALIU_OP_IO_SET, `ALIU_STAT_ADDR, 3'h1, 8'h03);
		chk(stat_q, 8'h00);
		issue(`ALIU_OP_IO_SET, 16'h0000, 8'h00, 8'h00, 6'h20, 3'h0);
		chk({op_error_q, io_re_q, res_valid_q}, 3'b100);
		$display("io bit test done");
	endtask

	task automatic report_and_stop;
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		rst_n = 1'b0;
		cf = 1'b0;
		{op_valid, op_code, dst_lo, dst_hi, src_operand, imm, io_sel, io_bit, stat_evt} = '0;
		repeat (3) @(posedge mclk);
		chk({op_ready_q, flags_q, stat_q}, 17'h10000);
		rst_n <= 1'b1;
		t_byte;
		t_logic;
		t_word;
		t_io;
		report_and_stop;
	end

	// Whole run is about sixty cycles
	initial
	begin
		#20000;
		errors++;
		report_and_stop;
	end
endmodule // aliu_core_test

`default_nettype wire
